// ==== logic/output_compare_pkg.sv ====
`default_nettype none
package output_compare_pkg;

   // ******************************
   // register offsets
   // ******************************
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] VALUE_OFFSET = 8'h04;
   localparam logic [7:0] SELECT_OFFSET = 8'h08;
   localparam logic [7:0] FLAG_OFFSET = 8'h0C;
   localparam logic [7:0] ENABLE_OFFSET = 8'h10;
   localparam logic [7:0] PORT_OFFSET = 8'h14;
   localparam logic [7:0] STATUS_OFFSET = 8'h18;

   // ******************************
   // field positions
   // ******************************
   localparam int CTRL_WIDTH = 6;
   localparam int MODE_LSB = 0;
   localparam int MODE_MSB = 3;
   localparam int FLAG_BIT = 0;
   localparam int ENABLE_BIT = 0;
   localparam int DIR_BIT = 0;
   localparam int LATCH_BIT = 1;
   localparam int STAT_PIN_BIT = 0;
   localparam int STAT_LATCH_BIT = 1;
   localparam int STAT_INPUT_BIT = 2;
   localparam int STAT_EQUAL_BIT = 3;

   // ******************************
   // reset values
   // ******************************
   localparam logic [5:0] CTRL_RESET = 6'h00;
   localparam logic [15:0] VALUE_RESET = 16'h0000;
   localparam logic [1:0] SELECT_RESET = 2'h0;
   localparam logic DIR_RESET = 1'b1;
   localparam logic LATCH_RESET = 1'b0;

   // ******************************
   // mode and timer select codes
   // ******************************
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_TOGGLE = 4'h2;
   localparam logic [3:0] MODE_CAP_FALL = 4'h4;
   localparam logic [3:0] MODE_CAP_RISE = 4'h5;
   localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
   localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
   localparam logic [3:0] MODE_SET = 4'h8;
   localparam logic [3:0] MODE_CLEAR = 4'h9;
   localparam logic [3:0] MODE_SOFT = 4'hA;
   localparam logic [3:0] MODE_EVENT = 4'hB;
   localparam logic [1:0] SEL_TIMER_ONE = 2'h0;
   localparam logic [1:0] SEL_THREE_A = 2'h1;
   localparam logic [1:0] SEL_THREE_B = 2'h2;
   localparam logic [3:0] PRESCALE_FOUR = 4'h3;
   localparam logic [3:0] PRESCALE_SIXTEEN = 4'hF;

   typedef enum logic [6:0] {
      MK_OFF = 7'b0000001,
      MK_CAPTURE = 7'b0000010,
      MK_TOGGLE = 7'b0000100,
      MK_SET = 7'b0001000,
      MK_CLEAR = 7'b0010000,
      MK_SOFT = 7'b0100000,
      MK_EVENT = 7'b1000000
   } modeKind_t;

   function automatic modeKind_t decodeMode(input logic [3:0] code);
      case (code)
         MODE_TOGGLE: decodeMode = MK_TOGGLE;
         MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_RISE4, MODE_CAP_RISE16: decodeMode = MK_CAPTURE;
         MODE_SET: decodeMode = MK_SET;
         MODE_CLEAR: decodeMode = MK_CLEAR;
         MODE_SOFT: decodeMode = MK_SOFT;
         MODE_EVENT: decodeMode = MK_EVENT;
         default: decodeMode = MK_OFF;
      endcase
   endfunction

endpackage
`default_nettype wire

// ==== logic/capture_prescaler.sv ====
`timescale 1ns/1ns
`default_nettype none
module capture_prescaler
   import output_compare_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] modeCode,
   input wire logic pinLevel,
   output logic captureEvent
);

   logic prevLevel;
   logic [3:0] count;
   logic next_prevLevel;
   logic [3:0] next_count;
   logic next_captureEvent;
   logic rise;
   logic fall;
   logic isCapture;

   // ******************************
   // edge prescaler
   // ******************************
   always_comb begin
      rise = pinLevel && !prevLevel;
      fall = !pinLevel && prevLevel;
      isCapture = (decodeMode(modeCode) == MK_CAPTURE);
      next_prevLevel = pinLevel;
      next_count = count;
      next_captureEvent = 1'b0;
      if (!isCapture) begin
         next_count = 4'h0;
      end else if (rise) begin
         next_count = count + 4'h1;
      end
      case (modeCode)
         MODE_CAP_FALL: next_captureEvent = fall;
         MODE_CAP_RISE: next_captureEvent = rise;
         MODE_CAP_RISE4: next_captureEvent = rise && ((count & PRESCALE_FOUR) == PRESCALE_FOUR);
         MODE_CAP_RISE16: next_captureEvent = rise && (count == PRESCALE_SIXTEEN);
         default: next_captureEvent = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prevLevel <= 1'b0;
         count <= 4'h0;
         captureEvent <= 1'b0;
      end else begin
         prevLevel <= next_prevLevel;
         count <= next_count;
         captureEvent <= next_captureEvent;
      end
   end

   prescaler_clear_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      !isCapture |=> (count == 4'h0) && !captureEvent)
      else $error("prescaler not cleared outside capture");

endmodule
`default_nettype wire

// ==== logic/output_compare_unit.sv ====
// Notes on behaviour
// - The selected timer count is compared with the 16-bit compare value all the time, the first cycle of equality being a match.
// - A match drives the pin high, low, toggles it, or leaves it on the port latch, per the mode field.
// - A compare match sets the interrupt flag together with the pin action, and software clears it.
// - Writing zero to the whole control register forces the compare output latch low, apart from the port latch.
// - In the software interrupt mode a match leaves the pin alone and only raises the flag, whatever its enable.
// - In the special event mode a match resets the count of the assigned timer so the value acts as period.
// - The special event of this channel never starts a conversion and only resets the assigned timer.
// - The capture prescaler counter is cleared whenever the unit is off or not in capture mode.
`timescale 1ns/1ns
`default_nettype none
module output_compare_unit
   import output_compare_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] timerOneCount,
   input wire logic [15:0] timerThreeCount,
   output logic timerOneClear,
   output logic timerThreeClear,
   input wire logic pinIn,
   output logic pinOut,
   output logic pinOe_n,
   output logic compareIrq
);

   logic [5:0] ctrl;
   logic [15:0] value;
   logic [1:0] select;
   logic flag;
   logic enable;
   logic direction;
   logic portLatch;
   logic equalPrev;
   logic compareLatch;
   logic slvErr;
   logic pinSyncA;
   logic pinSyncB;
   logic [5:0] next_ctrl;
   logic [15:0] next_value;
   logic [1:0] next_select;
   logic next_flag;
   logic next_enable;
   logic next_direction;
   logic next_portLatch;
   logic next_equalPrev;
   logic next_compareLatch;
   logic next_pinOut;
   logic next_timerOneClear;
   logic next_timerThreeClear;
   logic [31:0] next_prdata;
   logic next_slvErr;
   logic next_pinSyncA;
   logic next_pinSyncB;
   modeKind_t kind;
   logic [15:0] selCount;
   logic selValid;
   logic equalNow;
   logic matchPulse;
   logic isCompare;
   logic drivesPin;
   logic captureEvent;
   logic setup;
   logic wrEn;
   logic wrCtrl;

   // ******************************
   // pin synchroniser
   // ******************************
   always_comb begin
      next_pinSyncA = pinIn;
      next_pinSyncB = pinSyncA;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pinSyncA <= 1'b0;
         pinSyncB <= 1'b0;
      end else begin
         pinSyncA <= next_pinSyncA;
         pinSyncB <= next_pinSyncB;
      end
   end

   // ******************************
   // match detection
   // ******************************
   always_comb begin
      kind = decodeMode(ctrl[MODE_MSB:MODE_LSB]);
      case (select)
         SEL_TIMER_ONE: begin
            selCount = timerOneCount;
            selValid = 1'b1;
         end
         SEL_THREE_A, SEL_THREE_B: begin
            selCount = timerThreeCount;
            selValid = 1'b1;
         end
         default: begin
            selCount = 16'h0000;
            selValid = 1'b0;
         end
      endcase
      equalNow = selValid && (selCount == value);
      matchPulse = equalNow && !equalPrev;
      isCompare = (kind == MK_TOGGLE) || (kind == MK_SET) || (kind == MK_CLEAR)
         || (kind == MK_SOFT) || (kind == MK_EVENT);
      drivesPin = (kind == MK_TOGGLE) || (kind == MK_SET) || (kind == MK_CLEAR);
   end

   capture_prescaler u_prescaler (
      .clk(clk),
      .rst_n(rst_n),
      .modeCode(ctrl[MODE_MSB:MODE_LSB]),
      .pinLevel(pinSyncB),
      .captureEvent(captureEvent)
   );

   // ******************************
   // apb slave
   // ******************************
   assign setup = psel && !penable;
   assign wrEn = psel && penable && pwrite;
   assign wrCtrl = wrEn && (paddr == CTRL_OFFSET);
   assign pready = 1'b1;
   assign pslverr = psel && penable && slvErr;

   always_comb begin
      next_prdata = prdata;
      next_slvErr = slvErr;
      if (setup) begin
         next_prdata = 32'h0000_0000;
         next_slvErr = 1'b0;
         case (paddr)
            CTRL_OFFSET: next_prdata[CTRL_WIDTH-1:0] = ctrl;
            VALUE_OFFSET: next_prdata[15:0] = value;
            SELECT_OFFSET: next_prdata[1:0] = select;
            FLAG_OFFSET: next_prdata[FLAG_BIT] = flag;
            ENABLE_OFFSET: next_prdata[ENABLE_BIT] = enable;
            PORT_OFFSET: begin
               next_prdata[DIR_BIT] = direction;
               next_prdata[LATCH_BIT] = portLatch;
            end
            STATUS_OFFSET: begin
               next_prdata[STAT_PIN_BIT] = pinOut;
               next_prdata[STAT_LATCH_BIT] = compareLatch;
               next_prdata[STAT_INPUT_BIT] = pinSyncB;
               next_prdata[STAT_EQUAL_BIT] = equalNow;
            end
            default: next_slvErr = 1'b1;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
         slvErr <= 1'b0;
      end else begin
         prdata <= next_prdata;
         slvErr <= next_slvErr;
      end
   end

   // ******************************
   // registers and compare actions
   // ******************************
   always_comb begin
      next_ctrl = ctrl;
      next_value = value;
      next_select = select;
      next_flag = flag;
      next_enable = enable;
      next_direction = direction;
      next_portLatch = portLatch;
      next_equalPrev = equalNow;
      next_compareLatch = compareLatch;
      if (wrEn) begin
         case (paddr)
            CTRL_OFFSET: next_ctrl = pwdata[CTRL_WIDTH-1:0];
            VALUE_OFFSET: next_value = pwdata[15:0];
            SELECT_OFFSET: next_select = pwdata[1:0];
            FLAG_OFFSET: begin
               if (pwdata[FLAG_BIT]) begin
                  next_flag = 1'b0;
               end
            end
            ENABLE_OFFSET: next_enable = pwdata[ENABLE_BIT];
            PORT_OFFSET: begin
               next_direction = pwdata[DIR_BIT];
               next_portLatch = pwdata[LATCH_BIT];
            end
            default: next_flag = next_flag;
         endcase
      end
      if (captureEvent) begin
         next_value = selCount;
      end
      if ((matchPulse && isCompare) || captureEvent) begin
         next_flag = 1'b1;
      end
      if (matchPulse) begin
         case (kind)
            MK_TOGGLE: next_compareLatch = !compareLatch;
            MK_SET: next_compareLatch = 1'b1;
            MK_CLEAR: next_compareLatch = 1'b0;
            default: next_compareLatch = compareLatch;
         endcase
      end
      if (wrCtrl && (pwdata[CTRL_WIDTH-1:0] == CTRL_RESET)) begin
         next_compareLatch = LATCH_RESET;
      end
      next_pinOut = (drivesPin && !wrCtrl) ? next_compareLatch : next_portLatch;
      if (wrCtrl && (decodeMode(pwdata[MODE_MSB:MODE_LSB]) inside {MK_TOGGLE, MK_SET, MK_CLEAR})) begin
         next_pinOut = next_compareLatch;
      end
      // special event goes to timer reset only, no conversion start
      next_timerOneClear = matchPulse && (kind == MK_EVENT) && (select == SEL_TIMER_ONE);
      next_timerThreeClear = matchPulse && (kind == MK_EVENT)
         && ((select == SEL_THREE_A) || (select == SEL_THREE_B));
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= CTRL_RESET;
         value <= VALUE_RESET;
         select <= SELECT_RESET;
         flag <= 1'b0;
         enable <= 1'b0;
         direction <= DIR_RESET;
         portLatch <= LATCH_RESET;
         equalPrev <= 1'b0;
         compareLatch <= LATCH_RESET;
         pinOut <= LATCH_RESET;
         timerOneClear <= 1'b0;
         timerThreeClear <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         value <= next_value;
         select <= next_select;
         flag <= next_flag;
         enable <= next_enable;
         direction <= next_direction;
         portLatch <= next_portLatch;
         equalPrev <= next_equalPrev;
         compareLatch <= next_compareLatch;
         pinOut <= next_pinOut;
         timerOneClear <= next_timerOneClear;
         timerThreeClear <= next_timerThreeClear;
      end
   end

   assign pinOe_n = direction;
   assign compareIrq = flag && enable;

   // ******************************
   // checks
   // ******************************
   continuous_match_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (selValid && (selCount == value) && !equalPrev && isCompare) |=> flag)
      else $error("equal count did not raise flag");

   match_sets_flag_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (matchPulse && isCompare) |=> flag ##0 (compareIrq == enable))
      else $error("match lost its flag");

   toggle_on_match_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (matchPulse && (kind == MK_TOGGLE) && !wrCtrl) |=> (compareLatch != $past(compareLatch)) && (pinOut == compareLatch))
      else $error("toggle mode did not toggle");

   set_clear_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (matchPulse && !wrCtrl && ((kind == MK_SET) || (kind == MK_CLEAR)))
      |=> (compareLatch == $past(kind == MK_SET)) && (pinOut == compareLatch))
      else $error("set or clear mode gave wrong level");

   zero_ctrl_low_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (wrCtrl && (pwdata[CTRL_WIDTH-1:0] == CTRL_RESET)) |=> !compareLatch ##1 !compareLatch || (kind != MK_OFF))
      else $error("clearing control left latch high");

   soft_pin_alone_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (matchPulse && (kind == MK_SOFT) && !wrEn) |=> $stable(compareLatch) && (pinOut == portLatch) && flag)
      else $error("soft interrupt mode touched the pin");

   event_resets_timer_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (matchPulse && (kind == MK_EVENT) && selValid) |=> (timerOneClear || timerThreeClear) ##1 !timerOneClear)
      else $error("special event did not reset timer");

   event_only_timer_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (timerOneClear || timerThreeClear) |-> $past(matchPulse) && ($past(kind) == MK_EVENT))
      else $error("timer reset without special event");

   once_per_tick_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (equalNow && $stable(selCount) && $stable(value)) |=> !matchPulse)
      else $error("standing equal count matched twice");

   flag_clear_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (wrEn && (paddr == FLAG_OFFSET) && pwdata[FLAG_BIT] && !(matchPulse && isCompare)
      && !captureEvent) |=> !flag)
      else $error("flag not cleared by software");

   pin_shows_latch_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (drivesPin && !wrCtrl) |=> (pinOut == compareLatch))
      else $error("drive mode pin differs from latch");

   pin_port_latch_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (!drivesPin && !wrCtrl) |=> (pinOut == portLatch))
      else $error("pin left the port latch");

   event_mode_only_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (kind != MK_EVENT) |=> !timerOneClear && !timerThreeClear)
      else $error("timer reset outside special event mode");

   clear_one_cycle_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (timerOneClear || timerThreeClear) |=> !timerOneClear && !timerThreeClear)
      else $error("timer reset held too long");

   irq_needs_enable_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      compareIrq |-> enable && flag)
      else $error("interrupt without enable");

endmodule
`default_nettype wire

// ==== sim/timer_pair_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module timer_pair_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [15:0] loadVal,
   input wire logic timerOneClear,
   input wire logic timerThreeClear,
   input wire logic pinOut,
   input wire logic pinOe_n,
   input wire logic extLevel,
   output logic [15:0] timerOneCount,
   output logic [15:0] timerThreeCount,
   output logic pinIn
);
   // ****************
   // synchronous timers
   // ****************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timerOneCount <= 16'h0000;
         timerThreeCount <= 16'h0000;
      end else if (load) begin
         timerOneCount <= loadVal;
         timerThreeCount <= loadVal;
      end else begin
         if (timerOneClear) timerOneCount <= 16'h0000;
         if (timerThreeClear) timerThreeCount <= 16'h0000;
      end
   end
   // ****************
   // pin line, external source when released
   // ****************
   assign pinIn = pinOe_n ? extLevel : pinOut;
endmodule
`default_nettype wire

// ==== sim/tb_output_compare_unit.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_output_compare_unit
   import output_compare_pkg::*;
   ;
   logic clk = 1'h0;
   logic rst_n, psel, penable, pwrite, load, extLevel, pready, pslverr, er, expLatch, ev;
   logic timerOneClear, timerThreeClear, pinIn, pinOut, pinOe_n, compareIrq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] timerOneCount, timerThreeCount, loadVal, v;
   integer errCount = 0;
   integer testsRun = 0;
   integer seed = 32'hD438CC43;
   integer i, k;
   logic [7:0] offTab [6] = '{CTRL_OFFSET, VALUE_OFFSET, SELECT_OFFSET, FLAG_OFFSET, ENABLE_OFFSET, PORT_OFFSET};
   logic [3:0] modeTab [8] = '{MODE_SET, MODE_CLEAR, MODE_TOGGLE, MODE_TOGGLE, MODE_SOFT, MODE_SOFT, MODE_EVENT,
      MODE_EVENT};
   logic [1:0] selTab [8] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0};
   logic enTab [8] = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1};
   logic [3:0] capTab [4] = '{MODE_CAP_RISE4, MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_RISE16};
   integer capNeed [4] = '{4, 1, 1, 16};

   always #4 clk = ~clk;

   output_compare_unit dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timerOneCount(timerOneCount), .timerThreeCount(timerThreeCount), .timerOneClear(timerOneClear),
      .timerThreeClear(timerThreeClear), .pinIn(pinIn), .pinOut(pinOut), .pinOe_n(pinOe_n),
      .compareIrq(compareIrq));

   timer_pair_model far (.clk(clk), .rst_n(rst_n), .load(load), .loadVal(loadVal),
      .timerOneClear(timerOneClear), .timerThreeClear(timerThreeClear), .pinOut(pinOut), .pinOe_n(pinOe_n),
      .extLevel(extLevel), .timerOneCount(timerOneCount), .timerThreeCount(timerThreeCount), .pinIn(pinIn));

   // ****************
   // shared tasks
   // ****************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      testsRun = testsRun + 1;
      if (seen !== exp) begin
         errCount = errCount + 1;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1) begin
         @(posedge clk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic setCount(input logic [15:0] c);
      @(posedge clk);
      load <= 1'h1;
      loadVal <= c;
      @(posedge clk);
      load <= 1'h0;
   endtask

   function automatic logic nextLatch(input logic [3:0] m, input logic l);
      if (m == MODE_SET) return 1'h1;
      if (m == MODE_CLEAR) return 1'h0;
      if (m == MODE_TOGGLE) return ~l;
      return l;
   endfunction

   // drive modes show the compare latch, the rest the port latch (set to 1)
   function automatic logic expPin(input logic [3:0] m, input logic l);
      return (m == MODE_SET || m == MODE_CLEAR || m == MODE_TOGGLE) ? l : 1'h1;
   endfunction

   task automatic endOfTest;
      $display("checks %0d mismatches %0d", testsRun, errCount);
      if (errCount == 0 && testsRun > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ****************
   // watchdog
   // ****************
   initial begin
      #400000;
      errCount = errCount + 1;
      $display("watchdog expired");
      endOfTest;
   end

   // ****************
   // main sequence
   // ****************
   initial begin
      rst_n = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      load = 1'h0;
      loadVal = 16'h0;
      extLevel = 1'h0;
      repeat (16) @(posedge clk);
      rst_n <= 1'h1;
      for (i = 0; i < 6; i++) begin
         apb(1'h0, offTab[i], 32'h0);
         chk(rd, (i == 5) ? {30'h0, LATCH_RESET, DIR_RESET} : 32'h0);
      end
      chk(pinOe_n, 1'h1);
      apb(1'h0, 8'h1C, 32'h0);
      chk(er, 1'h1);
      chk(rd, 32'h0);
      $display("test reset values done");
      apb(1'h1, PORT_OFFSET, 32'h2);
      apb(1'h0, PORT_OFFSET, 32'h0);
      chk(rd, 32'h2);
      chk(pinOe_n, 1'h0);
      for (i = 0; i < 8; i++) begin
         v = 16'($random(seed));
         apb(1'h1, VALUE_OFFSET, {16'h0, v});
         if (i == 0 || modeTab[i] != modeTab[i - 1]) begin
            apb(1'h1, CTRL_OFFSET, 32'h0);
            expLatch = 1'h0;
            apb(1'h0, STATUS_OFFSET, 32'h0);
            chk(rd[STAT_LATCH_BIT], 1'h0);
         end
         apb(1'h1, SELECT_OFFSET, {30'h0, selTab[i]});
         apb(1'h1, ENABLE_OFFSET, {31'h0, enTab[i]});
         apb(1'h1, CTRL_OFFSET, {28'h0, modeTab[i]});
         apb(1'h0, VALUE_OFFSET, 32'h0);
         chk(rd, {16'h0, v});
         setCount(v);
         @(posedge clk);
         @(negedge clk);
         expLatch = nextLatch(modeTab[i], expLatch);
         ev = (modeTab[i] == MODE_EVENT);
         chk(pinOut, expPin(modeTab[i], expLatch));
         chk(compareIrq, enTab[i]);
         chk(timerOneClear, ev && selTab[i] == 2'h0);
         chk(timerThreeClear, ev && selTab[i] != 2'h0);
         repeat (6) @(posedge clk);
         chk(pinOut, expPin(modeTab[i], expLatch));
         apb(1'h0, FLAG_OFFSET, 32'h0);
         chk(rd, 32'h1);
         apb(1'h1, FLAG_OFFSET, 32'h1);
         apb(1'h0, FLAG_OFFSET, 32'h0);
         chk(rd, 32'h0);
         chk(compareIrq, 1'h0);
         $display("test compare mode %h done", modeTab[i]);
      end
      apb(1'h1, SELECT_OFFSET, 32'h3);
      apb(1'h1, CTRL_OFFSET, {28'h0, MODE_SET});
      setCount(v);
      repeat (4) @(posedge clk);
      chk(pinOut, 1'h0);
      chk(compareIrq, 1'h0);
      $display("test no timer selected done");
      apb(1'h1, SELECT_OFFSET, 32'h0);
      apb(1'h1, PORT_OFFSET, 32'h1);
      apb(1'h1, ENABLE_OFFSET, 32'h1);
      for (i = 0; i < 4; i++) begin
         v = 16'($random(seed));
         apb(1'h1, CTRL_OFFSET, 32'h0);
         apb(1'h1, FLAG_OFFSET, 32'h1);
         setCount(v);
         apb(1'h1, CTRL_OFFSET, {28'h0, capTab[i]});
         for (k = 1; k <= capNeed[i]; k++) begin
            @(posedge clk);
            extLevel <= 1'h0;
            repeat (4) @(posedge clk);
            extLevel <= 1'h1;
            repeat (8) @(posedge clk);
            chk(compareIrq, k == capNeed[i]);
         end
         apb(1'h0, VALUE_OFFSET, 32'h0);
         chk(rd, {16'h0, v});
         $display("test capture mode %h done", capTab[i]);
      end
      endOfTest;
   end
endmodule
`default_nettype wire
